// File: hdl/mcpi_pkg.sv
// Shared constants and types for the motion controller pin interface
// What this block does
// R01: Address strobe latches low six bus bits
// R02: Select with write stores data at address
// R03: Select with read fills output latch only
// R04: Output enable drives output latch onto bus
// R05: Encoder supplies two channels ninety degrees apart
// R06: Index either polarity, used for commutation only
// R07: Low limit input sets limit flag
// R08: Limit flag forces idle and zero command
// R09: Limit entry leaves control mode flags unchanged
// R10: Low stop input sets stop flag
// R11: Stop in integral velocity holds zero velocity
// R12: Flag clears after input high plus status write
// R13: Sync input acts only in idle mode
// R14: Sync low clears and holds sample timer
// R15: Sync high restarts timer from programmed value
// R16: Host pulses shared sync line low
// R17: Motor command on eight bit port, bit7 MSB
// R18: PWM at clock/100, width in 100 steps
// R19: Direction output gives motor command sign
// R20: Profile output high during trapezoid move
// R21: Idle output high in idle mode
// R22: Reset input forces hard reset, reset mode
// R23: Count up when B leads A
// R24: Encoder input valid after three stable edges
// R25: Command port mirrors motor command register
// R26: Limit wins over stop, idle, zero command
package mcpi_pkg;
   // Bus geometry
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   // Register addresses
   localparam logic [5:0] ADDR_FLAG = 6'h00;
   localparam logic [5:0] ADDR_STATUS = 6'h07;
   localparam logic [5:0] ADDR_MOTOR_CMD = 6'h08;
   localparam logic [5:0] ADDR_PWM_CMD = 6'h09;
   localparam logic [5:0] ADDR_TIMER = 6'h0F;
   localparam logic [5:0] ADDR_POS_MSB = 6'h12;
   localparam logic [5:0] ADDR_POS_MID = 6'h13;
   localparam logic [5:0] ADDR_POS_LSB = 6'h14;
   localparam logic [5:0] ADDR_MODE = 6'h3F;
   // Status register field positions
   localparam int ST_PROF_BIT = 4;
   localparam int ST_INIT_BIT = 5;
   localparam int ST_STOP_BIT = 6;
   localparam int ST_LIMIT_BIT = 7;
   // Flag register: control mode flag positions
   localparam int FL_POS_MODE_BIT = 0;
   localparam int FL_VEL_A_BIT = 3;
   localparam int FL_VEL_B_BIT = 5;
   // Reset values
   localparam logic [7:0] MOTOR_CMD_ZERO = 8'h80;
   localparam logic [7:0] TIMER_RESET = 8'h40;
   // PWM frame: clock / 100
   localparam logic [6:0] PWM_PERIOD = 7'h64;
   localparam logic [6:0] PWM_LAST = 7'h63;
   // Encoder filter depth
   localparam int FILT_DEPTH = 3;
   localparam int POS_W = 24;
   // Controller modes
   typedef enum logic [2:0] {
      MCPI_RESET, MCPI_IDLE, MCPI_POSITION, MCPI_PROFILE, MCPI_INT_VEL
   } mcpi_mode_t;
endpackage

// File: hdl/mcpi_enc_if.sv
// Interface carrying filtered encoder events to the core
`timescale 1ns/10ps
`default_nettype none
interface mcpi_enc_if;
   logic count_up; // One-cycle up count
   logic count_dn; // One-cycle down count
   logic index_evt; // One-cycle index reference
   modport src (output count_up, output count_dn, output index_evt);
   modport dst (input count_up, input count_dn, input index_evt);
endinterface
`default_nettype wire

// File: hdl/mcpi_encoder.sv
// Encoder front end: synchroniser, three-edge filter, quadrature decode
`timescale 1ns/10ps
`default_nettype none
module mcpi_encoder (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Encoder pins
   input wire logic chan_a,
   input wire logic chan_b,
   input wire logic index_in,
   input wire logic index_act_high,
   // Events out
   mcpi_enc_if.src enc
);
   // All state in one record
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0][2:0] hist;
      logic [2:0] filt;
      logic up;
      logic dn;
      logic idx;
   } mcpi_enc_st_t;
   mcpi_enc_st_t st_r, st_nxt;
   logic [2:0] stable; // Per input: all history equal
   localparam int FILT_DEPTH_L = mcpi_pkg::FILT_DEPTH; // Samples that must agree

   // Filter stability per input
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_filt
         assign stable[g] = (st_r.hist[0][g] == st_r.hist[1][g]) &&
                            (st_r.hist[1][g] == st_r.hist[2][g]);
      end
   endgenerate

   // Next state
   always_comb begin
      logic a_o, b_o, a_n, b_n, idx_n;
      st_nxt = st_r;
      a_o = st_r.filt[0];
      b_o = st_r.filt[1];
      // Two flops before anything looks at pins
      st_nxt.s1 = {index_in ^ ~index_act_high, chan_b, chan_a}; // see R06
      st_nxt.s2 = st_r.s1;
      st_nxt.hist = {st_r.hist[1], st_r.hist[0], st_r.s2};
      for (int i = 0; i < FILT_DEPTH_L; i++) begin
         if (stable[i]) begin
            st_nxt.filt[i] = st_r.hist[0][i]; // see R24
         end
      end
      a_n = st_nxt.filt[0];
      b_n = st_nxt.filt[1];
      idx_n = st_nxt.filt[2];
      // B leads A: A follows B's old value
      st_nxt.up = 1'b0;
      st_nxt.dn = 1'b0;
      if ((a_n != a_o) && (b_n == b_o)) begin
         st_nxt.up = (a_n == b_o); // see R23
         st_nxt.dn = (a_n != b_o);
      end else if ((b_n != b_o) && (a_n == a_o)) begin
         st_nxt.up = (b_n != a_o); // see R23
         st_nxt.dn = (b_n == a_o);
      end
      // Index: filtered falling edge of normalised signal
      st_nxt.idx = st_r.filt[2] & ~idx_n; // see R06
   end

   // Register state
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign enc.count_up = st_r.up;
   assign enc.count_dn = st_r.dn;
   assign enc.index_evt = st_r.idx;
endmodule
`default_nettype wire

// File: hdl/mcpi_pwm.sv
// PWM generator: frame of 100 clocks, width from command magnitude
`timescale 1ns/10ps
`default_nettype none
module mcpi_pwm (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Command, two's complement
   input wire logic [7:0] pwm_cmd,
   // Outputs
   output logic pulse,
   output logic sign
);
   // All state in one record
   typedef struct packed {
      logic [6:0] cnt;
      logic [6:0] width;
      logic pulse;
      logic sign;
   } mcpi_pwm_st_t;
   mcpi_pwm_st_t st_r, st_nxt;

   // Next state
   always_comb begin
      logic [7:0] mag;
      st_nxt = st_r;
      mag = pwm_cmd[7] ? 8'(-pwm_cmd) : pwm_cmd;
      // Width clamps at full frame, which also absorbs -128
      if (st_r.cnt == mcpi_pkg::PWM_LAST) begin
         st_nxt.cnt = '0;
         st_nxt.width = (mag > 8'(mcpi_pkg::PWM_PERIOD)) ? mcpi_pkg::PWM_PERIOD
                                                        : mag[6:0]; // see R18
         st_nxt.sign = pwm_cmd[7]; // see R19
      end else begin
         st_nxt.cnt = 7'(st_r.cnt + 7'h01); // see R18
      end
      st_nxt.pulse = (st_nxt.cnt < st_nxt.width); // see R18
   end

   // Register state
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pulse = st_r.pulse;
   assign sign = st_r.sign;
endmodule
`default_nettype wire

// File: hdl/mcpi_top.sv
// Motion controller pin interface: host bus, flags, sync, command outputs
`timescale 1ns/10ps
`default_nettype none
module mcpi_top (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Host bus strobes
   input wire logic addr_latch_en,
   input wire logic chip_sel_n,
   input wire logic read_write,
   input wire logic out_en_n,
   // Host data, address and data multiplexed
   input wire logic [7:0] bus_in,
   output logic [7:0] bus_out,
   output logic bus_oe,
   // Encoder
   input wire logic chan_a,
   input wire logic chan_b,
   input wire logic index_in,
   input wire logic index_act_high,
   // Emergency pins, low means asserted
   input wire logic limit_n,
   input wire logic stop_n,
   // Shared sync line
   input wire logic sync_n,
   // Motor outputs
   output logic [7:0] motor_cmd,
   // Pulse width outputs
   output logic pwm_pulse,
   output logic pwm_sign,
   // Status outputs
   output logic prof,
   output logic init_idle,
   output logic [23:0] position,
   output logic index_seen
);
   // Synchronised pin bundle: ale, cs_n, rw, oe_n, limit_n, stop_n, sync_n
   // Every pin is asynchronous to clk, so each passes two flops first;
   // the price is about three clocks of latency on every strobe
   localparam int NSYNC = 7;
   // Idle pin levels: address strobe low, every other pin high
   localparam logic [NSYNC-1:0] SYNC_IDLE = 7'h7E;

   // All state in one record
   typedef struct packed {
      // First synchroniser stage of the pins
      logic [NSYNC-1:0] s1;
      // Second stage; only this one is read by logic
      logic [NSYNC-1:0] s2;
      // Bus data takes the same two-stage path
      logic [7:0] bus1;
      logic [7:0] bus2;
      // Data seen while select was still active
      logic [7:0] wdata;
      // Select one cycle back, for the release edge
      logic cs_d;
      // Internal address latch
      logic [5:0] addr;
      // Output latch and its drive enable
      logic [7:0] out_latch;
      logic bus_oe;
      // Mode flag storage, left alone by limit
      logic [7:0] flags;
      // Low four bits of the status register
      logic [3:0] status_cfg;
      // Emergency flags and pin-released markers
      logic limit_flag;
      logic stop_flag;
      logic limit_rel;
      logic stop_rel;
      // Offset binary port and signed PWM command
      logic [7:0] motor_cmd;
      logic [7:0] pwm_cmd;
      // Sample timer reload value and count
      logic [7:0] timer_prog;
      logic [7:0] timer;
      // Quadrature position count
      logic [23:0] pos;
      // Status flops, so pins never glitch
      logic prof;
      logic idle;
      logic idx;
      // Controller mode
      mcpi_pkg::mcpi_mode_t mode;
   } mcpi_st_t;
   mcpi_st_t st_r, st_nxt;
   mcpi_enc_if enc (); // Filtered encoder events

   // Synchronised views, second stage only
   // Strobes, made high-true where the pin is low-true
   logic ale_s, cs_s, rw_s, oe_s, lim_low, stp_low, sync_low;
   assign ale_s = st_r.s2[0];
   assign cs_s = ~st_r.s2[1];
   assign rw_s = st_r.s2[2];
   assign oe_s = ~st_r.s2[3];
   // Emergency and sync levels, high-true
   assign lim_low = ~st_r.s2[4];
   assign stp_low = ~st_r.s2[5];
   assign sync_low = ~st_r.s2[6];

   // Read multiplexer of internal locations
   // Reaches only the output latch, never the pins
   logic [7:0] rd_data;
   always_comb begin
      unique case (st_r.addr)
         mcpi_pkg::ADDR_FLAG: rd_data = st_r.flags;
         // Limit, stop, idle, profile, then configuration
         mcpi_pkg::ADDR_STATUS: begin
            rd_data = {st_r.limit_flag, st_r.stop_flag,
                       st_r.mode == mcpi_pkg::MCPI_IDLE, st_r.prof, st_r.status_cfg};
         end
         mcpi_pkg::ADDR_MOTOR_CMD: rd_data = st_r.motor_cmd;
         mcpi_pkg::ADDR_PWM_CMD: rd_data = st_r.pwm_cmd;
         mcpi_pkg::ADDR_TIMER: rd_data = st_r.timer_prog;
         // Bytes read one at a time, no snapshot, so a
         // carry between two reads can tear the value
         mcpi_pkg::ADDR_POS_MSB: rd_data = st_r.pos[23:16];
         mcpi_pkg::ADDR_POS_MID: rd_data = st_r.pos[15:8];
         mcpi_pkg::ADDR_POS_LSB: rd_data = st_r.pos[7:0];
         default: rd_data = 8'h00; // Unmapped locations read zero
      endcase
   end

   // Next state
   always_comb begin
      logic wr, rd, st_wr;
      st_nxt = st_r;
      // Pins into the first synchroniser stage
      st_nxt.s1 = {sync_n, stop_n, limit_n, out_en_n, read_write, chip_sel_n,
                   addr_latch_en};
      st_nxt.s2 = st_r.s1;
      st_nxt.bus1 = bus_in;
      st_nxt.bus2 = st_r.bus1;
      st_nxt.cs_d = cs_s;
      // Data sampled while select is active: the host may change it as
      // soon as select rises, and the release is seen two clocks late
      if (cs_s) begin
         st_nxt.wdata = st_r.bus2;
      end

      // Access completes on select release, like the pin's rising edge
      wr = st_r.cs_d && !cs_s && !rw_s;
      rd = st_r.cs_d && !cs_s && rw_s;
      st_wr = wr && (st_r.addr == mcpi_pkg::ADDR_STATUS);

      // Address latch, only while select is idle
      if (ale_s && !cs_s) begin
         st_nxt.addr = st_r.bus2[5:0]; // see R01
      end

      // Read into output latch, bus untouched
      if (rd) begin
         st_nxt.out_latch = rd_data; // see R03
      end
      // Output enable follows its pin after the synchroniser
      st_nxt.bus_oe = oe_s; // see R04

      // Writes take the data held from the select window
      if (wr) begin
         unique case (st_r.addr)
            mcpi_pkg::ADDR_FLAG: st_nxt.flags = st_r.wdata; // see R02
            mcpi_pkg::ADDR_STATUS: st_nxt.status_cfg = st_r.wdata[3:0]; // see R12
            mcpi_pkg::ADDR_MOTOR_CMD: st_nxt.motor_cmd = st_r.wdata; // see R02
            mcpi_pkg::ADDR_PWM_CMD: st_nxt.pwm_cmd = st_r.wdata; // see R02
            mcpi_pkg::ADDR_TIMER: st_nxt.timer_prog = st_r.wdata; // see R02
            mcpi_pkg::ADDR_MODE: begin
               // Profile flag follows entry to profile mode
               st_nxt.mode = mcpi_pkg::mcpi_mode_t'(st_r.wdata[2:0]);
               st_nxt.prof = (st_r.wdata[2:0] == 3'(mcpi_pkg::MCPI_PROFILE));
            end
            default: ;
         endcase
      end

      // Emergency flags: release needs pin high, then a status write
      // A status write while the pin is still low leaves the flag set,
      // and the write does not count toward a later release
      if (!lim_low && st_r.limit_flag) begin
         st_nxt.limit_rel = 1'b1;
      end
      if (!stp_low && st_r.stop_flag) begin
         st_nxt.stop_rel = 1'b1;
      end
      if (st_wr && st_r.limit_rel && !lim_low) begin
         st_nxt.limit_flag = 1'b0; // see R12
         st_nxt.limit_rel = 1'b0;
      end
      if (st_wr && st_r.stop_rel && !stp_low) begin
         st_nxt.stop_flag = 1'b0; // see R12
         st_nxt.stop_rel = 1'b0;
      end

      // Setting wins over clearing
      // A fresh low in the cycle of the clearing write keeps the flag
      if (lim_low) begin
         st_nxt.limit_flag = 1'b1; // see R07
         st_nxt.limit_rel = 1'b0;
      end
      if (stp_low) begin
         st_nxt.stop_flag = 1'b1; // see R10
         st_nxt.stop_rel = 1'b0;
      end

      // Sample timer; sync only counts while idle
      if (st_r.mode == mcpi_pkg::MCPI_IDLE && sync_low) begin
         st_nxt.timer = 8'h00; // see R13 R14
      end else if (st_r.timer == 8'h00) begin
         // Reload at zero, so a sync release restarts the count at once
         st_nxt.timer = st_r.timer_prog; // see R15
      end else begin
         st_nxt.timer = 8'(st_r.timer - 8'h01); // see R15
      end

      // Control-mode handling; limit acts in any cycle, only the stop ramp waits for the sample boundary
      // Reset mode lasts a single cycle, then the controller idles
      if (st_r.mode == mcpi_pkg::MCPI_RESET) begin
         st_nxt.mode = mcpi_pkg::MCPI_IDLE;
      end
      // Limit is tested first, so it wins over stop
      if (st_r.limit_flag && st_r.mode != mcpi_pkg::MCPI_IDLE &&
          st_r.mode != mcpi_pkg::MCPI_RESET) begin
         st_nxt.mode = mcpi_pkg::MCPI_IDLE; // see R08 R26
         st_nxt.motor_cmd = mcpi_pkg::MOTOR_CMD_ZERO; // see R08
         st_nxt.pwm_cmd = 8'h00;
         st_nxt.prof = 1'b0;
         st_nxt.flags = st_r.flags; // see R09
      end else if (st_r.stop_flag && st_r.mode == mcpi_pkg::MCPI_INT_VEL) begin
         // Stop acts only here, in integral velocity mode
         // Ramp toward zero by one step per sample
         // The ramp ends on the zero code, never past it
         if (st_r.timer == 8'h00 && st_r.motor_cmd != mcpi_pkg::MOTOR_CMD_ZERO) begin
            st_nxt.motor_cmd = (st_r.motor_cmd > mcpi_pkg::MOTOR_CMD_ZERO) ?
                               8'(st_r.motor_cmd - 8'h01) :
                               8'(st_r.motor_cmd + 8'h01); // see R11
         end
         st_nxt.pwm_cmd = 8'(st_nxt.motor_cmd ^ mcpi_pkg::MOTOR_CMD_ZERO); // see R11
      end

      // Position counter
      // The decoder never raises both directions in one cycle
      if (enc.count_up) begin
         st_nxt.pos = 24'(st_r.pos + 24'h000001); // see R23
      end else if (enc.count_dn) begin
         st_nxt.pos = 24'(st_r.pos - 24'h000001); // see R23
      end
      // Index event passed on as a one-cycle flop
      st_nxt.idx = enc.index_evt; // see R06
      // Idle status kept in a flop so the pin comes from a register
      st_nxt.idle = (st_nxt.mode == mcpi_pkg::MCPI_IDLE); // see R21
   end

   // Register state; reset sends the controller to reset mode
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_r <= '0; // see R22
         // Idle pin levels, so no false strobe follows reset
         st_r.s1 <= SYNC_IDLE;
         st_r.s2 <= SYNC_IDLE;
         st_r.motor_cmd <= mcpi_pkg::MOTOR_CMD_ZERO;
         st_r.timer_prog <= mcpi_pkg::TIMER_RESET;
         st_r.mode <= mcpi_pkg::MCPI_RESET; // see R22
      end else begin
         st_r <= st_nxt;
      end
   end

   // Encoder front end
   // Its events arrive filtered and one cycle wide
   mcpi_encoder u_enc (
      .clk(clk),
      .reset_n(reset_n),
      .chan_a(chan_a),
      .chan_b(chan_b),
      .index_in(index_in),
      .index_act_high(index_act_high),
      .enc(enc)
   );

   // PWM generator
   // It takes the signed command; the port register is offset binary
   mcpi_pwm u_pwm (
      .clk(clk),
      .reset_n(reset_n),
      .pwm_cmd(st_r.pwm_cmd),
      .pulse(pwm_pulse),
      .sign(pwm_sign)
   );

   // Outputs, all from flops
   // Bus side: the latch shows only while enable stands
   assign bus_out = st_r.out_latch; // see R04
   assign bus_oe = st_r.bus_oe; // see R04
   // Motor side
   assign motor_cmd = st_r.motor_cmd; // see R17 R25
   // Status side
   assign prof = st_r.prof; // see R20
   assign init_idle = st_r.idle; // see R21
   assign position = st_r.pos;
   assign index_seen = st_r.idx;
endmodule
`default_nettype wire

// File: tb/mcpi_checker.sv
// Concurrent checks on the pin interface outputs
`timescale 1ns/10ps
`default_nettype none
module mcpi_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Watched inputs
   input wire logic out_en_n,
   input wire logic limit_n,
   input wire logic chan_a,
   input wire logic chan_b,
   // Watched outputs
   input wire logic bus_oe,
   input wire logic [7:0] motor_cmd,
   input wire logic pwm_pulse,
   input wire logic prof,
   input wire logic init_idle,
   input wire logic [23:0] position,
   input wire logic index_seen
);
   // Single clock domain, so clock and reset are stated once
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_reset_quiet: assert property (
      $rose(reset_n) |-> (!bus_oe && motor_cmd == 8'h80 && !pwm_pulse) ##[1:2] init_idle)
      else $error("outputs not at rest after reset");
   a_oe_drive: assert property (bus_oe |-> !$past(out_en_n, 3))
      else $error("bus driven without output enable");
   a_oe_on: assert property ((!out_en_n) [*4] |-> bus_oe)
      else $error("bus not driven under output enable");
   a_limit_idle: assert property (
      $fell(limit_n) |-> ##[1:100] (init_idle && motor_cmd == 8'h80))
      else $error("limit did not force idle with zero command");
   a_idle_prof: assert property (init_idle |-> !prof)
      else $error("profile flag raised while idle");
   a_index_once: assert property (index_seen |=> !index_seen)
      else $error("index event longer than one cycle");
   a_pos_step: assert property (position == $past(position) ||
      position - $past(position) == 24'h1 || $past(position) - position == 24'h1)
      else $error("position moved by more than one count");
   a_enc_quiet: assert property (
      ($stable(chan_a) && $stable(chan_b)) [*8] |-> ##2 $stable(position))
      else $error("position moved with quiet encoder");
endmodule
bind mcpi_top mcpi_checker u_chk (.clk(clk), .reset_n(reset_n), .out_en_n(out_en_n),
   .limit_n(limit_n), .chan_a(chan_a), .chan_b(chan_b), .bus_oe(bus_oe),
   .motor_cmd(motor_cmd), .pwm_pulse(pwm_pulse), .prof(prof), .init_idle(init_idle),
   .position(position), .index_seen(index_seen));
`default_nettype wire

// File: tb/mcpi_host_model.sv
// Host processor model on the multiplexed bus and the shared sync line
`timescale 1ns/10ps
`default_nettype none
module mcpi_host_model (
   // Clock
   input wire logic clk,
   // Bus strobes and data
   output logic addr_latch_en,
   output logic chip_sel_n,
   output logic read_write,
   output logic out_en_n,
   output logic [7:0] bus_in,
   // Shared sync line
   output logic sync_n
);
   // Quiet bus from time zero
   initial begin
      addr_latch_en = 1'h0;
      chip_sel_n = 1'h1;
      read_write = 1'h1;
      out_en_n = 1'h1;
      bus_in = 8'h00;
      sync_n = 1'h1;
   end
   // Whole cycles, then step just past the edge
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // One access; levels held five cycles to clear the pin synchronisers
   task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic rd);
      addr_latch_en = 1'h1;
      bus_in = a;
      hold(5);
      addr_latch_en = 1'h0;
      bus_in = ~a; // Released lines never keep the old value
      hold(5);
      chip_sel_n = 1'h0;
      read_write = rd;
      bus_in = rd ? ~a : d;
      hold(5);
      chip_sel_n = 1'h1;
      bus_in = ~bus_in;
      hold(6);
      if (rd) begin
         out_en_n = 1'h0;
         hold(6);
         out_en_n = 1'h1;
         hold(4);
      end
   endtask
   // Low pulse on the shared line, longer than the minimum width
   task automatic sync_pulse;
      sync_n = 1'h0;
      hold(18);
      sync_n = 1'h1;
      hold(4);
   endtask
endmodule
`default_nettype wire

// File: tb/mcpi_top_tb_top.sv
// Self-checking bench for the motion controller pin interface
`timescale 1ns/10ps
`default_nettype none
module mcpi_top_tb_top;
   // Clock, reset and pins
   logic clk = 1'h0;
   logic reset_n = 1'h0;
   logic ale, cs_n, rw, oe_n, sync_n, bus_oe, pwm_pulse, pwm_sign, prof, init_idle, index_seen;
   logic [7:0] bus_in, bus_out, motor_cmd, v;
   logic chan_a = 1'h0, chan_b = 1'h0, index_in = 1'h0, index_act_high = 1'h1;
   logic limit_n = 1'h1, stop_n = 1'h1, oe_q = 1'h0;
   logic [23:0] position, exp_pos = 24'h0;
   logic [1:0] ph = 2'h0;
   logic [7:0] pw[5] = '{8'h19, 8'hE7, 8'h7F, 8'h81, 8'h00};
   // Bookkeeping; read expectations wait in a queue
   int errors = 0, n_compared = 0, seed = 33, n_idx = 0, n;
   logic [7:0] exp_q[$];
   always #4 clk = ~clk;
   mcpi_host_model host (.clk(clk), .addr_latch_en(ale), .chip_sel_n(cs_n),
      .read_write(rw), .out_en_n(oe_n), .bus_in(bus_in), .sync_n(sync_n));
   mcpi_top dut (.clk(clk), .reset_n(reset_n), .addr_latch_en(ale), .chip_sel_n(cs_n),
      .read_write(rw), .out_en_n(oe_n), .bus_in(bus_in), .bus_out(bus_out),
      .bus_oe(bus_oe), .chan_a(chan_a), .chan_b(chan_b), .index_in(index_in),
      .index_act_high(index_act_high), .limit_n(limit_n), .stop_n(stop_n),
      .sync_n(sync_n), .motor_cmd(motor_cmd), .pwm_pulse(pwm_pulse),
      .pwm_sign(pwm_sign), .prof(prof), .init_idle(init_idle), .position(position),
      .index_seen(index_seen));
   // Pin value comparison
   task automatic cmp_pin(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bus read data comparison
   task automatic cmp_bus(input logic [7:0] got, input logic [7:0] exp);
      cmp_pin({16'h0000, got}, {16'h0000, exp});
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      host.xfer({2'h0, a}, d, 1'h0);
   endtask
   // Note the expectation, then run the read
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.xfer({2'h0, a}, 8'h00, 1'h1);
   endtask
   // Read data is judged when the device starts to drive the bus
   always @(posedge clk) begin
      if (bus_oe === 1'h1 && oe_q !== 1'h1) begin
         cmp_bus(bus_out, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX);
      end
      oe_q <= bus_oe;
   end
   always @(posedge clk) if (index_seen === 1'h1) n_idx++;
   // Gray steps, B ahead of A when counting up
   task automatic enc(input int c, input logic up);
      repeat (c) begin
         ph = up ? ph + 2'h1 : ph - 2'h1;
         {chan_a, chan_b} = ph ^ (ph >> 1);
         exp_pos = up ? exp_pos + 24'h1 : exp_pos - 24'h1;
         tick(5);
      end
   endtask
   // Count high cycles over one whole frame
   task automatic pwm_try(input logic [7:0] d);
      int hi, mag;
      hi = 0;
      mag = d[7] ? 256 - int'(d) : int'(d);
      wr(mcpi_pkg::ADDR_PWM_CMD, d);
      tick(100);
      repeat (100) begin
         hi += (pwm_pulse === 1'h1);
         tick(1);
      end
      cmp_pin(24'(hi), 24'((mag > 100) ? 100 : mag));
      cmp_pin(pwm_sign, d[7]);
   endtask
   task automatic finish_test;
      if (exp_q.size() != 0) errors++;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Hang guard, well beyond the expected run
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      finish_test;
   end
   initial begin
      tick(4);
      reset_n = 1'h1;
      tick(3);
      cmp_pin({init_idle, motor_cmd}, 9'h180);
      v = 8'($random(seed));
      host.xfer({2'h3, mcpi_pkg::ADDR_MOTOR_CMD}, v, 1'h0);
      cmp_pin(motor_cmd, v);
      rd(mcpi_pkg::ADDR_MOTOR_CMD, v);
      wr(6'h3E, 8'hFF);
      rd(6'h3E, 8'h00); // Unmapped place reads zero
      foreach (pw[i]) pwm_try(pw[i]);
      pwm_try(8'($random(seed)));
      n = ($random(seed) & 15) + 1;
      enc(n, 1'h1);
      chan_a = ~chan_a; // Two-cycle spike must be filtered
      tick(2);
      chan_a = ~chan_a;
      tick(10);
      cmp_pin(position, exp_pos);
      enc(($random(seed) & 7) + 1, 1'h0);
      tick(10);
      cmp_pin(position, exp_pos);
      rd(mcpi_pkg::ADDR_POS_LSB, exp_pos[7:0]);
      index_in = 1'h1;
      tick(6);
      {index_act_high, index_in} = 2'h1;
      tick(10);
      index_in = 1'h0;
      tick(6);
      index_in = 1'h1;
      tick(10);
      cmp_pin(24'(n_idx), 24'h2);
      host.sync_pulse();
      wr(mcpi_pkg::ADDR_MODE, 8'h03);
      tick(4);
      cmp_pin({init_idle, prof}, 2'h1);
      wr(mcpi_pkg::ADDR_FLAG, 8'h29);
      limit_n = 1'h0;
      tick(100);
      cmp_pin({prof, init_idle, motor_cmd}, 10'h180);
      rd(mcpi_pkg::ADDR_FLAG, 8'h29);
      wr(mcpi_pkg::ADDR_STATUS, 8'h03);
      rd(mcpi_pkg::ADDR_STATUS, 8'hA3);
      limit_n = 1'h1;
      tick(10);
      rd(mcpi_pkg::ADDR_STATUS, 8'hA3);
      wr(mcpi_pkg::ADDR_STATUS, 8'h00);
      rd(mcpi_pkg::ADDR_STATUS, 8'h20);
      wr(mcpi_pkg::ADDR_MOTOR_CMD, 8'h90);
      wr(mcpi_pkg::ADDR_MODE, 8'h04);
      stop_n = 1'h0;
      tick(1300);
      cmp_pin({init_idle, motor_cmd}, 9'h080);
      rd(mcpi_pkg::ADDR_STATUS, 8'h40);
      limit_n = 1'h0;
      tick(100);
      cmp_pin({init_idle, motor_cmd}, 9'h180);
      {limit_n, stop_n} = 2'h3;
      tick(10);
      reset_n = 1'h0;
      tick(4);
      reset_n = 1'h1;
      tick(3);
      cmp_pin({init_idle, motor_cmd}, 9'h180);
      rd(mcpi_pkg::ADDR_STATUS, 8'h20);
      tick(10);
      finish_test;
   end
endmodule
`default_nettype wire
